//--- windowed_watchdog_service_check.sv
`timescale 1ns/100ps
`include "wdog_params.svh"
module windowed_watchdog_service_check (
  input wire logic core_clk_in, // core clock
  input wire logic nrst_in, // async reset, active low
  input wire logic clk_en_in, // freezes all state when low
  input wire logic wdog_option_in, // watchdog feature chosen
  input wire logic idle_tick_in, // one-cycle idle timer tick
  input wire logic instr_clk_in, // instruction-cycle clock, from outside
  input wire logic svc_wr_in, // write strobe to service register
  input wire logic svc_rd_in, // read strobe of service register
  input wire logic [7:0] svc_wdata_in, // write data
  output logic [7:0] svc_rdata_out, // read data, registered
  output logic wd_error_out, // watchdog error level
  output logic cmon_error_out, // clock monitor error level
  output logic error_out // combined error indication
);
  wdog_pkg::svc_word_t svc_ff, nxt_svc;
  wdog_pkg::wd_state_t state_ff, nxt_state;
  logic [16:0] upper_cnt_ff, nxt_upper_cnt;
  logic [16:0] lower_cnt_ff, nxt_lower_cnt;
  logic wd_err_ff, nxt_wd_err;
  logic cm_err_ff, nxt_cm_err;
  logic err_ff, nxt_err;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [2:0] ck_sync_ff, nxt_ck_sync;
  logic ck_level_ff, nxt_ck_level;
  logic [15:0] ck_cnt_ff, nxt_ck_cnt;
  logic [16:0] upper_limit;
  // decoded write checks and window controls
  logic key_ok;
  logic word_ok;
  logic lower_open;
  logic service;
  logic counting;
  logic upper_hit;
  logic restart;

  // write word checks
  always_comb
  begin
    key_ok = (svc_wdata_in[`KEY_HI:`KEY_LO] == `KEY_VALUE);
    word_ok = key_ok && (svc_wdata_in[`WSEL_HI:`WSEL_LO] == svc_ff.wsel)
              && (svc_wdata_in[`CMON_BIT] == svc_ff.cmon);
    lower_open = (lower_cnt_ff >= `LOWER_TICKS);
    service = svc_wr_in && wdog_option_in;
    // both limit units only see ticks while the watchdog is live
    counting = idle_tick_in && wdog_option_in && (state_ff != wdog_pkg::ST_OFF);
    case (svc_ff.wsel)
      2'h0: upper_limit = `UPPER_8K;
      2'h1: upper_limit = `UPPER_16K;
      2'h2: upper_limit = `UPPER_32K;
      default: upper_limit = `UPPER_64K;
    endcase
    // the tick that brings the count to the limit ends the window
    upper_hit = counting && (upper_cnt_ff + 17'h00001 >= upper_limit);
  end

  // service state, register contents and the watchdog error
  always_comb
  begin
    nxt_state = state_ff;
    nxt_svc = svc_ff;
    nxt_wd_err = wd_err_ff;
    restart = 1'b0;
    case (state_ff)
      wdog_pkg::ST_OFF:
      begin
        if (wdog_option_in)
        begin
          // arming restarts both windows from zero
          nxt_state = wdog_pkg::ST_ARMED;
          restart = 1'b1;
        end
      end
      wdog_pkg::ST_ARMED, wdog_pkg::ST_LOCKED:
      begin
        if (!wdog_option_in)
        begin
          nxt_state = wdog_pkg::ST_OFF;
          nxt_wd_err = 1'b0;
        end
        else
        begin
          // upper window ran out before a service came in
          if (upper_hit)
          begin
            nxt_wd_err = 1'b1;
          end
          if (service && !wd_err_ff)
          begin
            if (state_ff == wdog_pkg::ST_ARMED)
            begin
              // first write: the key gates the one-time window and monitor choice
              if (key_ok)
              begin
                nxt_svc.wsel = svc_wdata_in[`WSEL_HI:`WSEL_LO];
                nxt_svc.cmon = svc_wdata_in[`CMON_BIT];
                nxt_state = wdog_pkg::ST_LOCKED;
              end
              else
              begin
                // a wrong key on the first write is an error at once
                nxt_wd_err = 1'b1;
              end
            end
            else if (!word_ok)
            begin
              // locked: a write must carry the key and repeat the stored window and monitor bits
              nxt_wd_err = 1'b1;
            end
            if (!lower_open)
            begin
              // too soon after the last restart: a runaway service loop
              nxt_wd_err = 1'b1;
            end
            // any taken write restarts both windows, good or bad
            restart = 1'b1;
          end
        end
      end
      default: nxt_state = wdog_pkg::ST_OFF;
    endcase
  end

  // upper limit unit: idle ticks since the last restart
  // saturation keeps a long stall from wrapping back into the window
  always_comb
  begin
    nxt_upper_cnt = upper_cnt_ff;
    if (restart)
    begin
      nxt_upper_cnt = 17'h00000;
    end
    else if (counting && upper_cnt_ff != 17'h1ffff)
    begin
      nxt_upper_cnt = upper_cnt_ff + 17'h00001;
    end
  end

  // lower limit unit: runs up to the fixed lower limit and parks there
  // once parked the window stays open until the next restart
  always_comb
  begin
    nxt_lower_cnt = lower_cnt_ff;
    if (restart)
    begin
      nxt_lower_cnt = 17'h00000;
    end
    else if (counting && !lower_open)
    begin
      nxt_lower_cnt = lower_cnt_ff + 17'h00001;
    end
  end

  // clock monitor: sync instruction clock, time out on missing edges
  always_comb
  begin
    nxt_ck_sync = {ck_sync_ff[1:0], instr_clk_in};
    nxt_ck_level = ck_level_ff;
    nxt_ck_cnt = ck_cnt_ff;
    nxt_cm_err = cm_err_ff;
    if (ck_sync_ff[2] == ck_sync_ff[1] && ck_sync_ff[1] != ck_level_ff)
    begin
      nxt_ck_level = ck_sync_ff[1];
      nxt_ck_cnt = 16'h0000;
      nxt_cm_err = 1'b0;
    end
    else if (ck_cnt_ff != `CMON_TIMEOUT)
      nxt_ck_cnt = ck_cnt_ff + 16'h0001;
    else if (svc_ff.cmon && wdog_option_in)
      nxt_cm_err = 1'b1;
    if (!svc_ff.cmon || !wdog_option_in)
      nxt_cm_err = 1'b0;
  end

  // read data: the key field always reads back as zero
  // a cycle without a read strobe leaves the last value in place
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (svc_rd_in)
    begin
      // only the stored window and monitor choice are visible
      nxt_rdata = {svc_ff.wsel, 5'h00, svc_ff.cmon};
    end
  end

  // merged error from the next values, so it rises with either flag
  always_comb
  begin
    nxt_err = nxt_wd_err || nxt_cm_err;
  end

  // service group: state, stored word, limit counters, watchdog error
  // the stored word resets to the widest window with the monitor on
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_ff <= wdog_pkg::ST_OFF;
      svc_ff <= `SVC_RESET;
      upper_cnt_ff <= 17'h00000;
      lower_cnt_ff <= 17'h00000;
      wd_err_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_ff <= nxt_state;
      svc_ff <= nxt_svc;
      upper_cnt_ff <= nxt_upper_cnt;
      lower_cnt_ff <= nxt_lower_cnt;
      wd_err_ff <= nxt_wd_err;
    end
  end

  // instruction clock synchroniser, one flip-flop per stage
  // stage 0 feeds only stage 1, so a metastable level never fans out
  for (genvar gi = 0; gi < 3; gi++)
  begin : g_ck_sync
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        ck_sync_ff[gi] <= 1'b0;
      end
      else if (clk_en_in)
      begin
        ck_sync_ff[gi] <= nxt_ck_sync[gi];
      end
    end
  end

  // clock monitor group: settled level, silence counter, monitor error
  // the counter stops at the timeout so the error cannot wrap away
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ck_level_ff <= 1'b0;
      ck_cnt_ff <= 16'h0000;
      cm_err_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      ck_level_ff <= nxt_ck_level;
      ck_cnt_ff <= nxt_ck_cnt;
      cm_err_ff <= nxt_cm_err;
    end
  end

  // read data register
  // software sees the value latched by the most recent read strobe
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_ff <= 8'h00;
    end
    else if (clk_en_in)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // merged error register
  // registered so the combined indication carries no decode glitches
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      err_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      err_ff <= nxt_err;
    end
  end

  // every output comes straight from a flip-flop
  // nothing combinational reaches a pin of this block
  assign svc_rdata_out = rdata_ff;
  assign wd_error_out = wd_err_ff;
  assign cmon_error_out = cm_err_ff;
  assign error_out = err_ff;
endmodule : windowed_watchdog_service_check

//--- wdog_params.svh
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH
// service register field positions
`define WSEL_HI 7
`define WSEL_LO 6
`define KEY_HI 5
`define KEY_LO 1
`define CMON_BIT 0
// key pattern and reset value (max window, monitor on)
`define KEY_VALUE 5'h0c
`define SVC_RESET 8'hc1
// window limits in idle ticks
`define LOWER_TICKS 17'h00800
`define UPPER_8K 17'h02000
`define UPPER_16K 17'h04000
`define UPPER_32K 17'h08000
`define UPPER_64K 17'h10000
// clock monitor timeout in core cycles without an instruction-clock edge
`define CMON_TIMEOUT 16'hffff
`endif

//--- wdog_pkg.sv
package wdog_pkg;
  typedef struct packed {
    logic [1:0] wsel;
    logic [4:0] key;
    logic cmon;
  } svc_word_t;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_ARMED,
    ST_LOCKED
  } wd_state_t;
endpackage : wdog_pkg

//--- svc_check_monitor.sv
`timescale 1ns/100ps
`include "wdog_params.svh"
module svc_check_monitor (
  input wire logic core_clk_in, // clock
  input wire logic nrst_in, // reset
  input wire logic clk_en_in, // run
  input wire logic wdog_option_in, // option
  input wire logic idle_tick_in, // tick
  input wire logic instr_clk_in, // instr clock
  input wire logic svc_wr_in, // write
  input wire logic svc_rd_in, // read
  input wire logic [7:0] svc_wdata_in, // wdata
  input wire logic [7:0] svc_rdata_out, // rdata
  input wire logic wd_error_out, // wd error
  input wire logic cmon_error_out, // cmon error
  input wire logic error_out // any error
);
  logic live_ff;
  logic nxt_live;
  logic wr_ok;
  // tracks the option as the block sees it
  always_comb nxt_live = clk_en_in ? wdog_option_in : live_ff;
  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in) live_ff <= 1'b0;
    else live_ff <= nxt_live;
  // a write that the block takes
  assign wr_ok = svc_wr_in && clk_en_in && wdog_option_in && live_ff && !wd_error_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_err_merge: assert property (error_out == (wd_error_out | cmon_error_out))
    else $error("merged error wrong");
  chk_off_clears: assert property (!wdog_option_in && clk_en_in |=> !wd_error_out)
    else $error("error with option off");
  chk_bad_key: assert property (wr_ok && svc_wdata_in[5:1] != `KEY_VALUE |=> wd_error_out)
    else $error("bad key not flagged");
  chk_err_sticky: assert property (wd_error_out && wdog_option_in |=> wd_error_out)
    else $error("error dropped");
  chk_no_cause: assert property (!wd_error_out && !svc_wr_in && !idle_tick_in |=> !wd_error_out)
    else $error("error without cause");
  chk_b2b_early: assert property (wr_ok && $past(wr_ok) |=> wd_error_out)
    else $error("early service missed");
  chk_key_hidden: assert property (svc_rd_in && clk_en_in |=> svc_rdata_out[5:1] == 5'h00)
    else $error("key visible");
  chk_rdata_hold: assert property (!svc_rd_in |=> $stable(svc_rdata_out))
    else $error("rdata moved");
  cov_error: cover property ($rose(wd_error_out));
  cov_service: cover property (wr_ok && svc_wdata_in[5:1] == `KEY_VALUE);
  cov_read: cover property (svc_rd_in && clk_en_in);
endmodule : svc_check_monitor

//--- windowed_watchdog_service_check_tb.sv
`timescale 1ns/100ps
module windowed_watchdog_service_check_tb;
  typedef struct {logic [7:0] d; int n; logic e;} row_t;
  row_t rows[4] = '{'{8'h18, 2048, 1'b0}, '{8'h18, 2047, 1'b1},
                    '{8'h1a, 2048, 1'b1}, '{8'hd9, 2048, 1'b0}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic opt = 1'b1;
  logic en = 1'b1;
  logic tick = 1'b0;
  logic iclk = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wde;
  logic cme;
  logic err;
  int fail_count = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  // instruction clock toggles every core cycle, too fast for the monitor filter; runs between resets stay under the timeout
  always @(negedge clk) iclk <= ~iclk;
  windowed_watchdog_service_check u_windowed_watchdog_service_check (.core_clk_in(clk),
    .nrst_in(nrst), .clk_en_in(en), .wdog_option_in(opt), .idle_tick_in(tick),
    .instr_clk_in(iclk), .svc_wr_in(wr), .svc_rd_in(rd), .svc_wdata_in(wdata),
    .svc_rdata_out(rdata), .wd_error_out(wde), .cmon_error_out(cme), .error_out(err));
  task chk_bit(input logic g, input logic x);
    tests_run++;
    if (g !== x)
    begin
      $display("CHECK FAILED %0t error flag %b", $time, g);
      fail_count++;
    end
  endtask : chk_bit
  task chk_byte(input logic [7:0] g, input logic [7:0] x);
    tests_run++;
    if (g !== x)
    begin
      $display("CHECK FAILED %0t read %h", $time, g);
      fail_count++;
    end
  endtask : chk_byte
  task do_reset;
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset
  task ticks(input int n);
    tick = 1'b1;
    repeat (n) @(negedge clk);
    tick = 1'b0;
  endtask : ticks
  task svc(input logic [7:0] d, input int k);
    wdata = d;
    wr = 1'b1;
    repeat (k) @(negedge clk);
    wr = 1'b0;
  endtask : svc
  task rd_chk(input logic [7:0] x);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk_byte(rdata, x);
  endtask : rd_chk
  task report_and_stop;
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #640000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    @(negedge clk);
    do_reset();
    rd_chk(8'hc1);
    chk_bit(cme, 1'b0);
    foreach (rows[i])
    begin
      do_reset();
      ticks(rows[i].n);
      svc(rows[i].d, 1);
      chk_bit(wde, rows[i].e);
      chk_bit(err, rows[i].e);
    end
    // a write while the clock enable is low must not be seen
    do_reset();
    ticks(2048);
    en = 1'b0;
    svc(8'h1a, 1);
    chk_bit(wde, 1'b0);
    en = 1'b1;
    svc(8'h1a, 1);
    chk_bit(wde, 1'b1);
    do_reset();
    ticks(2048);
    svc(8'h58, 1);
    rd_chk(8'h40);
    ticks(2048);
    svc(8'h58, 1);
    chk_bit(wde, 1'b0);
    ticks(2048);
    svc(8'h98, 1);
    chk_bit(wde, 1'b1);
    opt = 1'b0;
    @(negedge clk);
    svc(8'h00, 1);
    chk_bit(wde, 1'b0);
    opt = 1'b1;
    do_reset();
    ticks(2048);
    svc(8'h18, 2);
    chk_bit(wde, 1'b1);
    do_reset();
    ticks(2048);
    svc(8'h18, 1);
    ticks(8191);
    chk_bit(wde, 1'b0);
    ticks(1);
    chk_bit(wde, 1'b1);
    report_and_stop();
  end
endmodule : windowed_watchdog_service_check_tb
bind windowed_watchdog_service_check svc_check_monitor u_svc_check_monitor (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
  .wdog_option_in(wdog_option_in), .idle_tick_in(idle_tick_in), .instr_clk_in(instr_clk_in),
  .svc_wr_in(svc_wr_in), .svc_rd_in(svc_rd_in), .svc_wdata_in(svc_wdata_in),
  .svc_rdata_out(svc_rdata_out), .wd_error_out(wd_error_out),
  .cmon_error_out(cmon_error_out), .error_out(error_out));
